// ### design/lbdo_top.sv
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/100ps
// What this block does
// - Four independent output lines and one input line.
// - A strobe-enable bit makes line four a binning strobe.
// - Strobe goes true over 10 us after each completed reading test that arrives while no pulse is running.
// - Enabling the strobe forces the strobe line false at once.
// - Disabling the strobe returns line four to its manual bit or limit state.
// - Four-bit pass pattern applies when all enabled tests pass.
// - With strobe enabled, patterns never touch line four.
// - Enabling limit control loads the pass pattern immediately.
// - Limit control enabled with strobe enabled leaves line four to the strobe.
// - Each line has a manual on/off state bit.
// - Each line has its own polarity bit.
// - Pin level is logical value combined with polarity.
// - Lines come from manual bits or limit results per enables.
// - Under limit control, manual writes and reads are inert.
// - Input reads on when high, fixed polarity.
// - Test order low1, high1, low2, high2; first failure wins.
// - Each of four limits carries its own four-bit pattern.
// - Each limit set has its own control enable bit.
// - Active-high drives high when on, active-low drives low.
module lbdo_top
  import lbdo_pkg::*;
#(
  parameter int STROBE_CYCLES = LBDO_STROBE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reading_done,
  input wire logic [3:0] limit_fail,
  input wire logic digital_in,
  output logic [3:0] out_pins
);
  import lbdo_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [2:0] ctrl_r;
  logic [3:0] manual_r;
  logic [3:0] polarity_r;
  logic [3:0] pass_r;
  logic [15:0] pattern_r;
  logic [3:0] limit_state_r;
  logic [3:0] limit_state_nxt;
  logic [3:0] logic_out;
  logic [3:0] pin_nxt;
  logic in_sync;
  logic strobe;
  logic strobe_busy;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire wr_en = psel && penable && pwrite;
  wire sel_ctrl = (paddr == LBDO_CTRL_OFF);
  wire sel_manual = (paddr == LBDO_MANUAL_OFF);
  wire sel_pol = (paddr == LBDO_POLARITY_OFF);
  wire sel_pass = (paddr == LBDO_PASS_OFF);
  wire sel_pat = (paddr == LBDO_PATTERN_OFF);
  wire sel_stat = (paddr == LBDO_STATUS_OFF);
  wire mapped = sel_ctrl | sel_manual | sel_pol | sel_pass | sel_pat | sel_stat;
  wire [2:0] ctrl_wdata = pwdata[2:0];

  // Zero-wait slave; unmapped addresses answer with an error.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ----------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------
  wire set1_en = ctrl_r[LBDO_CTRL_SET1_BIT];
  wire set2_en = ctrl_r[LBDO_CTRL_SET2_BIT];
  wire limit_ctrl = set1_en | set2_en;
  wire strobe_en = ctrl_r[LBDO_CTRL_STROBE_BIT];
  wire ctrl_wr = wr_en && sel_ctrl;
  wire limit_ctrl_new = ctrl_wdata[LBDO_CTRL_SET1_BIT] | ctrl_wdata[LBDO_CTRL_SET2_BIT];
  wire limit_rise = ctrl_wr && limit_ctrl_new && !limit_ctrl;
  wire strobe_rise = ctrl_wr && ctrl_wdata[LBDO_CTRL_STROBE_BIT] && !strobe_en;

  // Pick the pattern of the first failing enabled test, else the pass pattern.
  function automatic logic [3:0] lbdo_select(
    input logic [3:0] fail,
    input logic s1,
    input logic s2,
    input logic [15:0] pats,
    input logic [3:0] pass
  );
    logic [3:0] r;
    r = pass;
    if (s2 && fail[3]) r = pats[15:12];
    if (s2 && fail[2]) r = pats[11:8];
    if (s1 && fail[1]) r = pats[7:4];
    if (s1 && fail[0]) r = pats[3:0];
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Limit-driven output state
  // ----------------------------------------------------------------
  always_comb begin
    limit_state_nxt = limit_state_r;
    if (limit_rise) begin
      limit_state_nxt = pass_r;
    end else if (limit_ctrl && reading_done) begin
      limit_state_nxt = lbdo_select(limit_fail, set1_en, set2_en, pattern_r, pass_r);
    end
  end

  // Logical line values: manual bits or limit state, line four to the strobe.
  always_comb begin
    logic_out = limit_ctrl ? limit_state_r : manual_r;
    if (strobe_en) begin
      logic_out[3] = strobe;
    end
  end

  // Polarity: a set bit means active low.
  assign pin_nxt = logic_out ^ polarity_r;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= LBDO_CTRL_RST;
      manual_r <= LBDO_NIBBLE_RST;
      polarity_r <= LBDO_NIBBLE_RST;
      pass_r <= LBDO_NIBBLE_RST;
      pattern_r <= LBDO_PATTERN_RST;
    end else if (wr_en) begin
      if (sel_ctrl) ctrl_r <= ctrl_wdata;
      if (sel_manual && !limit_ctrl) manual_r <= pwdata[3:0];
      if (sel_pol) polarity_r <= pwdata[3:0];
      if (sel_pass) pass_r <= pwdata[3:0];
      if (sel_pat) pattern_r <= pwdata[15:0];
    end
  end

  // Limit state and registered pins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_state_r <= LBDO_NIBBLE_RST;
      out_pins <= LBDO_NIBBLE_RST;
    end else begin
      limit_state_r <= limit_state_nxt;
      out_pins <= pin_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    prdata = 32'h0000_0000;
    if (sel_ctrl) prdata[2:0] = ctrl_r;
    if (sel_manual && !limit_ctrl) prdata[3:0] = manual_r;
    if (sel_pol) prdata[3:0] = polarity_r;
    if (sel_pass) prdata[3:0] = pass_r;
    if (sel_pat) prdata[15:0] = pattern_r;
    if (sel_stat) begin
      prdata[3:0] = logic_out;
      prdata[LBDO_STATUS_IN_BIT] = in_sync;
      prdata[LBDO_STATUS_BUSY_BIT] = strobe_busy;
    end
  end

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  lbdo_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(digital_in),
    .sync_out(in_sync)
  );

  lbdo_strobe #(.CYCLES(STROBE_CYCLES)) u_strobe (
    .pclk(pclk),
    .presetn(presetn),
    .enable(strobe_en),
    .enable_rise(strobe_rise),
    .fire(reading_done),
    .strobe(strobe),
    .busy(strobe_busy)
  );
endmodule // lbdo_top

// ### design/lbdo_pkg.sv
package lbdo_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] LBDO_CTRL_OFF = 12'h000;
  localparam logic [11:0] LBDO_MANUAL_OFF = 12'h004;
  localparam logic [11:0] LBDO_POLARITY_OFF = 12'h008;
  localparam logic [11:0] LBDO_PASS_OFF = 12'h00c;
  localparam logic [11:0] LBDO_PATTERN_OFF = 12'h010;
  localparam logic [11:0] LBDO_STATUS_OFF = 12'h014;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LBDO_CTRL_SET1_BIT = 0;
  localparam int LBDO_CTRL_SET2_BIT = 1;
  localparam int LBDO_CTRL_STROBE_BIT = 2;
  localparam int LBDO_STATUS_IN_BIT = 4;
  localparam int LBDO_STATUS_BUSY_BIT = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] LBDO_CTRL_RST = 3'h0;
  localparam logic [3:0] LBDO_NIBBLE_RST = 4'h0;
  localparam logic [15:0] LBDO_PATTERN_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int LBDO_CLK_HZ = 20_000_000;
  localparam int LBDO_STROBE_MIN_NS = 10_000;
  // Strictly longer than the minimum, so one cycle is added after rounding up.
  localparam int LBDO_STROBE_CYCLES =
      (LBDO_STROBE_MIN_NS * (LBDO_CLK_HZ / 1_000_000) + 999) / 1000 + 1;

  // ----------------------------------------------------------------
  // Strobe sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    LBDO_ST_IDLE = 1'b0,
    LBDO_ST_PULSE = 1'b1
  } lbdo_state_t;

endpackage

// ### design/lbdo_sync.sv
`timescale 1ns/100ps
// Two flip-flop synchroniser for the external input pin.
module lbdo_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_r;

  // Second stage is the only reader of the first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // lbdo_sync

// ### design/lbdo_strobe.sv
`timescale 1ns/100ps
// Binning strobe pulse generator.
module lbdo_strobe
  import lbdo_pkg::*;
#(
  parameter int CYCLES = LBDO_STROBE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic enable_rise,
  input wire logic fire,
  output logic strobe,
  output logic busy
);
  lbdo_state_t state_r;
  lbdo_state_t state_nxt;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic strobe_nxt;
  logic count_done;

  assign count_done = (count_r == 16'(CYCLES - 1));
  assign busy = (state_r == LBDO_ST_PULSE);

  // Next state: enabling forces false, disabled holds the level, pulses are counted.
  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    strobe_nxt = strobe;
    case (state_r)
      LBDO_ST_IDLE: begin
        if (enable && fire && !enable_rise) begin
          state_nxt = LBDO_ST_PULSE;
          count_nxt = 16'h0000;
          strobe_nxt = 1'b1;
        end
      end
      LBDO_ST_PULSE: begin
        count_nxt = count_r + 16'h0001;
        if (!enable) begin
          state_nxt = LBDO_ST_IDLE;
        end else if (count_done) begin
          state_nxt = LBDO_ST_IDLE;
          strobe_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = LBDO_ST_IDLE;
      end
    endcase
    if (enable_rise) begin
      state_nxt = LBDO_ST_IDLE;
      strobe_nxt = 1'b0;
    end
  end

  // State registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= LBDO_ST_IDLE;
      count_r <= 16'h0000;
      strobe <= 1'b0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      strobe <= strobe_nxt;
    end
  end
endmodule // lbdo_strobe

// ### tb/lbdo_top_asserts.sv
`timescale 1ns/100ps
// Port-side checker for the output block.
module lbdo_top_asserts
  import lbdo_pkg::*;
#(
  parameter int STROBE_CYCLES = LBDO_STROBE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic reading_done,
  input wire logic [3:0] limit_fail,
  input wire logic digital_in,
  input wire logic [3:0] out_pins
);
  logic [2:0] ctrl_r;
  logic [3:0] pol_r, pass_r, man_r;
  logic [15:0] hi_cnt_r;
  wire wr_en = psel & penable & pwrite & pready;
  wire mapped = (paddr <= LBDO_STATUS_OFF) && (paddr[1:0] == 2'h0);
  wire line4 = out_pins[3] ^ pol_r[3];
  // Shadows the written settings and counts strobe-high cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ctrl_r, pol_r, pass_r, man_r} <= 15'h0;
      hi_cnt_r <= 16'h0;
    end else begin
      if (wr_en && paddr == LBDO_CTRL_OFF) ctrl_r <= pwdata[2:0];
      if (wr_en && paddr == LBDO_POLARITY_OFF) pol_r <= pwdata[3:0];
      if (wr_en && paddr == LBDO_PASS_OFF) pass_r <= pwdata[3:0];
      if (wr_en && paddr == LBDO_MANUAL_OFF) man_r <= pwdata[3:0];
      hi_cnt_r <= line4 ? hi_cnt_r + 16'h1 : 16'h0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_fire;
    reading_done && ctrl_r[2] && $past(ctrl_r[2]);
  endsequence
  sequence s_ctrl_wr;
    wr_en && paddr == LBDO_CTRL_OFF;
  endsequence
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (psel && penable |-> pslverr == !mapped)
    else $error("bad pslverr");
  a_reset_pins: assert property (disable iff (1'b0) !presetn |-> out_pins == 4'h0)
    else $error("pins not cleared");
  a_strobe_rise: assert property (s_fire |-> ##2 line4) else $error("no strobe");
  a_strobe_width: assert property ($fell(line4) && ctrl_r[2] && $past(ctrl_r[2], 4)
    |-> hi_cnt_r == STROBE_CYCLES) else $error("strobe width");
  a_strobe_clear: assert property ((s_ctrl_wr and (pwdata[2] && !ctrl_r[2]))
    |-> ##2 !line4) else $error("strobe not cleared");
  a_pass_load: assert property ((s_ctrl_wr and (ctrl_r[1:0] == 2'h0 && pwdata[1:0] != 2'h0))
    |-> ##2 (out_pins ^ pol_r) == (ctrl_r[2] ? {1'b0, pass_r[2:0]} : pass_r))
    else $error("pass pattern");
  a_manual_drive: assert property (wr_en && paddr == LBDO_MANUAL_OFF && ctrl_r == 3'h0
    |-> ##2 out_pins == (man_r ^ pol_r)) else $error("manual drive");
endmodule // lbdo_top_asserts

bind lbdo_top lbdo_top_asserts #(.STROBE_CYCLES(STROBE_CYCLES)) chk_u (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .reading_done(reading_done), .limit_fail(limit_fail), .digital_in(digital_in),
  .out_pins(out_pins));

// ### tb/lbdo_handler.sv
`timescale 1ns/100ps
// Parts handler: delivers readings and latches the bin code on strobe rise.
module lbdo_handler (
  input wire logic pclk,
  input wire logic go,
  input wire logic [3:0] fails,
  input wire logic pin4,
  input wire logic [2:0] pins,
  output logic reading_done,
  output logic [3:0] limit_fail,
  output logic [2:0] bin_code
);
  logic pin4_r;
  initial {reading_done, limit_fail, bin_code, pin4_r} = 9'h0;
  // Flags are only meaningful beside the done pulse, so they scramble otherwise.
  always @(posedge pclk) begin
    reading_done <= go;
    limit_fail <= go ? fails : ~fails;
    pin4_r <= pin4;
    if (pin4 && !pin4_r) bin_code <= pins;
  end
endmodule // lbdo_handler

// ### tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  import lbdo_pkg::*;
  logic pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic go = 1'b0, din = 1'b0, pready, pslverr, rdone, e;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [3:0] fl = 4'h0, lfail, out_pins;
  logic [2:0] bin;
  int n_fail = 0, checks = 0, cyc = 0;
  // Clock of 50 ns period.
  always #25 pclk = ~pclk;
  lbdo_top #(.STROBE_CYCLES(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reading_done(rdone), .limit_fail(lfail),
    .digital_in(din), .out_pins(out_pins));
  lbdo_handler hnd_u (.pclk(pclk), .go(go), .fails(fl), .pin4(out_pins[3]),
    .pins(out_pins[2:0]), .reading_done(rdone), .limit_fail(lfail), .bin_code(bin));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Ends a hung run.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      print_verdict;
    end
  end
  task automatic pause(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One APB transfer; read data and error are taken at the completing edge.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic reading(input logic [3:0] f);
    @(posedge pclk);
    go <= 1'b1;
    fl <= f;
    @(posedge pclk);
    go <= 1'b0;
    pause(4);
  endtask
  function automatic logic [31:0] exp_out(input logic [3:0] f, input logic [1:0] en);
    exp_out = 32'h9;
    for (int i = 3; i >= 0; i--)
      if (f[i] && en[i / 2]) exp_out = (32'h4321 >> (i * 4)) & 32'hf;
  endfunction
  task automatic t_regs;
    for (int a = 0; a <= 24; a += 4) begin
      xfer(1'b0, 12'(a), 32'h0);
      chk(q, 32'h0);
    end
    chk({31'h0, e}, 32'h1);
    xfer(1'b1, LBDO_PATTERN_OFF, 32'h4321);
    xfer(1'b0, LBDO_PATTERN_OFF, 32'h0);
    chk(q, 32'h4321);
  endtask
  task automatic t_manual;
    xfer(1'b1, LBDO_POLARITY_OFF, 32'h5);
    xfer(1'b1, LBDO_MANUAL_OFF, 32'h3);
    pause(2);
    chk({28'h0, out_pins}, 32'h6);
    din <= 1'b1;
    pause(4);
    xfer(1'b0, LBDO_STATUS_OFF, 32'h0);
    chk(q, 32'h13);
    din <= 1'b0;
  endtask
  task automatic t_limits;
    logic [31:0] fs;
    fs = 32'hf0c68421;
    xfer(1'b1, LBDO_POLARITY_OFF, 32'h0);
    xfer(1'b1, LBDO_PASS_OFF, 32'h9);
    xfer(1'b1, LBDO_CTRL_OFF, 32'h3);
    pause(2);
    chk({28'h0, out_pins}, 32'h9);
    for (int k = 0; k < 8; k++) begin
      reading(fs[k * 4 +: 4]);
      chk({28'h0, out_pins}, exp_out(fs[k * 4 +: 4], 2'h3));
    end
    xfer(1'b1, LBDO_MANUAL_OFF, 32'h6);
    xfer(1'b0, LBDO_MANUAL_OFF, 32'h0);
    chk(q, 32'h0);
    chk({28'h0, out_pins}, 32'h1);
    xfer(1'b1, LBDO_CTRL_OFF, 32'h1);
    reading(4'h4);
    chk({28'h0, out_pins}, 32'h9);
  endtask
  task automatic t_strobe;
    xfer(1'b1, LBDO_CTRL_OFF, 32'h0);
    xfer(1'b1, LBDO_MANUAL_OFF, 32'h8);
    pause(2);
    chk({28'h0, out_pins}, 32'h8);
    xfer(1'b1, LBDO_CTRL_OFF, 32'h4);
    pause(2);
    chk({28'h0, out_pins}, 32'h0);
    xfer(1'b1, LBDO_CTRL_OFF, 32'h7);
    pause(2);
    chk({28'h0, out_pins}, 32'h1);
    reading(4'h2);
    pause(8);
    chk({29'h0, bin}, 32'h2);
    chk({28'h0, out_pins}, 32'h2);
  endtask
  // Reset, then each scenario in turn.
  initial begin
    // A real falling edge at time zero, so every flop sees its reset before the first clock.
    presetn <= 1'b0;
    pause(16);
    presetn <= 1'b1;
    t_regs;
    t_manual;
    t_limits;
    t_strobe;
    print_verdict;
  end
endmodule // testbench
